// File: flash_data_memory_control.v
// Contract
// - Address then read trigger loads data register.
// - Data register holds until read or write.
// - Stall execution during a read cycle.
// - Eight rows of eight bytes; row erase.
// - Erase row comes from address bits 5:3.
// - Erase select drops without next-cycle enable.
// - Write enable drops without next-cycle launch.
// - Stall execution during an erase cycle.
// - Enable and launch accepted only via bit-set.
// - Write order: address, data, enable, launch.
// - Write and erase need the completed unlock.
// - Next instruction runs without an idle slot.
// - Code protection never blocks array access.
// - Array reached only through the three registers.
`timescale 1ns/100ps
`include "nvm_defines.vh"

module flash_data_memory_control (
	// Clock and reset.
	input  wire       clk_in,
	input  wire       reset_n_in,
	// Register port from the core.
	input  wire [1:0] reg_addr_in,
	input  wire [7:0] reg_wdata_in,
	input  wire       reg_write_in,
	input  wire       reg_read_in,
	input  wire       bit_set_instruction_in,
	output reg  [7:0] reg_rdata_out,
	// Execution stall towards the core.
	output reg        stall_out
);

	// ======================================================================
	// Sequencer states.
	// ======================================================================
	localparam [2:0] ST_IDLE  = 3'h0;
	localparam [2:0] ST_READ  = 3'h1;
	localparam [2:0] ST_LOAD  = 3'h2;
	localparam [2:0] ST_ERASE = 3'h3;
	localparam [2:0] ST_WRITE = 3'h4;
	localparam [2:0] ST_WAIT  = 3'h5;
	localparam [2:0] ST_DONE  = 3'h6;

	// Programming time in clocks. It is worked out as a 32-bit number and
	// cut on purpose to the width of the wait counter, which holds it with room.
	localparam [31:0] PROG_CYCLES_FULL = `NVM_PROG_CYCLES;
	localparam [7:0]  PROG_CYCLES      = PROG_CYCLES_FULL[7:0];

	// ======================================================================
	// Registers and their next values.
	// ======================================================================
	reg [5:0] nvm_address_reg;
	reg [5:0] nvm_address_next;
	reg [7:0] nvm_data_reg;
	reg [7:0] nvm_data_next;
	reg       read_trigger_bit_reg;
	reg       read_trigger_bit_next;
	reg       cycle_launch_bit_reg;
	reg       cycle_launch_bit_next;
	reg       write_enable_bit_reg;
	reg       write_enable_bit_next;
	reg       row_erase_select_reg;
	reg       row_erase_select_next;
	// The fresh flags mark that enable or erase select was set by the
	// instruction just before; living one cycle each, they time the unlock.
	reg       write_enable_bit_fresh_reg;
	reg       write_enable_bit_fresh_next;
	reg       erase_fresh_reg;
	reg       erase_fresh_next;
	reg [2:0] state_reg;
	reg [2:0] state_next;
	reg [2:0] byte_cnt_reg;
	reg [2:0] byte_cnt_next;
	reg [7:0] wait_cnt_reg;
	reg [7:0] wait_cnt_next;
	reg [7:0] rdata_next;

	// Array port signals.
	reg       mem_wr_en;
	reg [5:0] mem_wr_addr;
	reg [7:0] mem_wr_data;
	reg       mem_rd_en;
	wire [7:0] mem_rd_data;

	// Decoded control-register access.
	wire       ctrl_write;
	wire [7:0] ctrl_value;
	wire [7:0] rising_bits;
	wire       set_read;
	wire       set_launch;
	wire       set_write_enable_bit;
	wire       idle;

	// Control writes count only while idle; during a cycle the bus cannot
	// disturb the sequence or the selected row.
	assign idle        = (state_reg == ST_IDLE);
	assign ctrl_write  = reg_write_in && (reg_addr_in == `NVM_OFS_CONTROL) && idle;
	assign ctrl_value  = {1'b0, 2'b00, row_erase_select_reg, 1'b0,
		write_enable_bit_reg, cycle_launch_bit_reg, read_trigger_bit_reg};
	assign rising_bits = reg_wdata_in & ~ctrl_value;

	// Trigger, enable and launch are honoured only from a bit-set instruction.
	assign set_read   = ctrl_write && bit_set_instruction_in &&
		rising_bits[`NVM_BIT_READ];
	assign set_write_enable_bit   = ctrl_write && bit_set_instruction_in &&
		rising_bits[`NVM_BIT_WRITE_ENABLE_BIT];
	assign set_launch = ctrl_write && bit_set_instruction_in &&
		rising_bits[`NVM_BIT_LAUNCH];

	// ======================================================================
	// Cell array. Protection settings have no path into it.
	// ======================================================================
	nvm_array u_array (
		.clk_in      (clk_in),
		.wr_en_in    (mem_wr_en),
		.wr_addr_in  (mem_wr_addr),
		.wr_data_in  (mem_wr_data),
		.rd_en_in    (mem_rd_en),
		.rd_addr_in  (nvm_address_reg),
		.rd_data_out (mem_rd_data)
	);

	// ======================================================================
	// Next-state logic of the sequencer and the control bits.
	// ======================================================================
	always @* begin
		nvm_address_next      = nvm_address_reg;
		nvm_data_next         = nvm_data_reg;
		read_trigger_bit_next = read_trigger_bit_reg;
		cycle_launch_bit_next = cycle_launch_bit_reg;
		write_enable_bit_next = write_enable_bit_reg;
		row_erase_select_next = row_erase_select_reg;
		write_enable_bit_fresh_next       = 1'b0;
		erase_fresh_next      = 1'b0;
		state_next            = state_reg;
		byte_cnt_next         = byte_cnt_reg;
		wait_cnt_next         = wait_cnt_reg;
		mem_wr_en             = 1'b0;
		mem_wr_addr           = nvm_address_reg;
		mem_wr_data           = nvm_data_reg;
		mem_rd_en             = 1'b0;
		case (state_reg)
			ST_IDLE: begin
				// Address and data load only while no cycle runs.
				if (reg_write_in && (reg_addr_in == `NVM_OFS_ADDRESS)) begin
					nvm_address_next = reg_wdata_in[5:0];
				end
				if (reg_write_in && (reg_addr_in == `NVM_OFS_DATA)) begin
					nvm_data_next = reg_wdata_in;
				end
				// Enable lapses unless the launch comes in the very next cycle.
				if (write_enable_bit_fresh_reg && !set_launch) begin
					write_enable_bit_next = 1'b0;
				end
				// Erase select lapses unless enable comes in the next cycle.
				if (erase_fresh_reg && !set_write_enable_bit) begin
					row_erase_select_next = 1'b0;
				end
				if (ctrl_write) begin
					// Any instruction may change the erase select bit.
					if (!bit_set_instruction_in || rising_bits[`NVM_BIT_ERASE]) begin
						row_erase_select_next = reg_wdata_in[`NVM_BIT_ERASE];
						erase_fresh_next = reg_wdata_in[`NVM_BIT_ERASE] &&
							!row_erase_select_reg;
					end
					if (!reg_wdata_in[`NVM_BIT_WRITE_ENABLE_BIT]) begin
						write_enable_bit_next = 1'b0;
					end
				end
				// For an erase, enable must follow the select at once.
				// A bit-set that raises select and enable together skips
				// a step of the unlock, so its enable is refused.
				if (set_write_enable_bit && !rising_bits[`NVM_BIT_ERASE] &&
					(!row_erase_select_reg || erase_fresh_reg)) begin
					write_enable_bit_next = 1'b1;
					write_enable_bit_fresh_next = 1'b1;
				end
				if (set_read) begin
					read_trigger_bit_next = 1'b1;
					mem_rd_en = 1'b1;
					state_next = ST_READ;
				end else if (set_launch && write_enable_bit_fresh_reg && write_enable_bit_reg) begin
					// Launch accepted only straight after an accepted enable.
					cycle_launch_bit_next = 1'b1;
					byte_cnt_next = 3'h0;
					if (row_erase_select_reg) begin
						state_next = ST_ERASE;
					end else begin
						state_next = ST_WRITE;
					end
				end
			end
			ST_READ: begin
				// Array data is registered; it appears now and is taken into
				// the data register at the edge that ends ST_LOAD, so the core waits two
				// cycles in all for a read.
				state_next = ST_LOAD;
			end
			ST_LOAD: begin
				nvm_data_next = mem_rd_data;
				read_trigger_bit_next = 1'b0;
				state_next = ST_IDLE;
			end
			ST_ERASE: begin
				// Clear all eight bytes of the row picked by address bits 5:3.
				// One byte per clock keeps the array to a single write port.
				mem_wr_en = 1'b1;
				mem_wr_addr = {nvm_address_reg[`NVM_ROW_MSB:`NVM_ROW_LSB],
					byte_cnt_reg};
				mem_wr_data = `NVM_ERASED;
				byte_cnt_next = byte_cnt_reg + 3'h1;
				if (byte_cnt_reg == 3'h7) begin
					wait_cnt_next = PROG_CYCLES;
					state_next = ST_WAIT;
				end
			end
			ST_WRITE: begin
				// Exactly one byte is programmed.
				mem_wr_en = 1'b1;
				wait_cnt_next = PROG_CYCLES;
				state_next = ST_WAIT;
			end
			ST_WAIT: begin
				// Cell programming time, counted in clocks.
				// Bus writes are ignored meanwhile, so the cells are not disturbed.
				wait_cnt_next = wait_cnt_reg - 8'h01;
				if (wait_cnt_reg == 8'h01) begin
					state_next = ST_DONE;
				end
			end
			ST_DONE: begin
				// Launch, enable and erase select drop as the cycle ends.
				// The core may start a new operation in the very next cycle.
				cycle_launch_bit_next = 1'b0;
				write_enable_bit_next = 1'b0;
				row_erase_select_next = 1'b0;
				state_next = ST_IDLE;
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	// ======================================================================
	// Read data multiplexer; unused offset and spare bits read as zero, control bit 7 reads busy.
	// Reads are answered during a stall as well; only writes are held off.
	// ======================================================================
	always @* begin
		rdata_next = 8'h00;
		if (reg_read_in) begin
			case (reg_addr_in)
				`NVM_OFS_ADDRESS: rdata_next = {2'b00, nvm_address_reg};
				`NVM_OFS_DATA:    rdata_next = nvm_data_reg;
				`NVM_OFS_CONTROL: rdata_next = ctrl_value | {!idle, 7'h00};
				default:          rdata_next = 8'h00;
			endcase
		end
	end

	// ======================================================================
	// State registers.
	// Every flip-flop of the block outside the cell array sits here, so reset reaches them all at once.
	// ======================================================================
	always @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			nvm_address_reg      <= 6'h00;
			nvm_data_reg         <= `NVM_RESET_BYTE;
			read_trigger_bit_reg <= 1'b0;
			cycle_launch_bit_reg <= 1'b0;
			write_enable_bit_reg <= 1'b0;
			row_erase_select_reg <= 1'b0;
			write_enable_bit_fresh_reg       <= 1'b0;
			erase_fresh_reg      <= 1'b0;
			state_reg            <= ST_IDLE;
			byte_cnt_reg         <= 3'h0;
			wait_cnt_reg         <= 8'h00;
			reg_rdata_out        <= 8'h00;
			stall_out            <= 1'b0;
		end else begin
			nvm_address_reg      <= nvm_address_next;
			nvm_data_reg         <= nvm_data_next;
			read_trigger_bit_reg <= read_trigger_bit_next;
			cycle_launch_bit_reg <= cycle_launch_bit_next;
			write_enable_bit_reg <= write_enable_bit_next;
			row_erase_select_reg <= row_erase_select_next;
			write_enable_bit_fresh_reg       <= write_enable_bit_fresh_next;
			erase_fresh_reg      <= erase_fresh_next;
			state_reg            <= state_next;
			byte_cnt_reg         <= byte_cnt_next;
			wait_cnt_reg         <= wait_cnt_next;
			reg_rdata_out        <= rdata_next;
			// Stall is high for every cycle the sequencer is away from idle.
			// It follows the next state, so the core halts in the cycle after
			// the trigger and resumes with the following instruction.
			stall_out            <= (state_next != ST_IDLE);
		end
	end

endmodule // flash_data_memory_control

// File: nvm_array.v
`timescale 1ns/100ps

// ==========================================================================
// Flash cell array: one write port, one read port with registered data.
// ==========================================================================
module nvm_array (
	// Clock.
	input  wire                   clk_in,
	// Write port.
	input  wire                   wr_en_in,
	input  wire [5:0]             wr_addr_in,
	input  wire [7:0]             wr_data_in,
	// Read port.
	input  wire                   rd_en_in,
	input  wire [5:0]             rd_addr_in,
	output reg  [7:0]             rd_data_out
);

	reg [7:0] cell_mem [0:63];

	// Cells are written and read on the rising edge; read data is registered.
	always @(posedge clk_in) begin
		if (wr_en_in) begin
			cell_mem[wr_addr_in] <= wr_data_in;
		end
		if (rd_en_in) begin
			rd_data_out <= cell_mem[rd_addr_in];
		end
	end

endmodule // nvm_array

// File: nvm_core_model.sv
`timescale 1ns/100ps

// ==========================================================================
// Core side: issues register writes, bit-set writes and reads.
// ==========================================================================
module nvm_core_model (
	// Clock.
	input  wire        clk_in,
	// Register port towards the controller.
	output logic [1:0] addr_out,
	output logic [7:0] wdata_out,
	output logic       wr_out,
	output logic       rd_out,
	output logic       bs_out
);
	// Bus starts quiet.
	initial begin
		addr_out = 2'h0;
		wdata_out = 8'h00;
		wr_out = 1'b0;
		rd_out = 1'b0;
		bs_out = 1'b0;
	end

	// One write cycle; a bit-set write carries the whole new register value.
	task automatic wr(input logic [1:0] a, input logic [7:0] d, input logic bs);
		addr_out <= a;
		wdata_out <= d;
		wr_out <= 1'b1;
		rd_out <= 1'b0;
		bs_out <= bs;
		@(posedge clk_in);
	endtask

	// One read cycle.
	task automatic rd(input logic [1:0] a);
		addr_out <= a;
		wr_out <= 1'b0;
		rd_out <= 1'b1;
		bs_out <= 1'b0;
		@(posedge clk_in);
	endtask

	// Idle cycles; released lines toggle so no stale value is mistaken for data.
	task automatic idle(input int n);
		repeat (n) begin
			wr_out <= 1'b0;
			rd_out <= 1'b0;
			bs_out <= 1'b0;
			addr_out <= ~addr_out;
			wdata_out <= ~wdata_out;
			@(posedge clk_in);
		end
	endtask
endmodule // nvm_core_model

// File: nvm_ctrl_properties.sv
`timescale 1ns/100ps

// ==========================================================================
// Port checks of the flash data memory controller.
// ==========================================================================
module nvm_ctrl_properties (
	// Clock and reset.
	input wire       clk_in,
	input wire       reset_n_in,
	// Register port and stall.
	input wire [1:0] reg_addr_in,
	input wire [7:0] reg_wdata_in,
	input wire       reg_write_in,
	input wire       reg_read_in,
	input wire       bit_set_instruction_in,
	input wire [7:0] reg_rdata_out,
	input wire       stall_out
);
	logic [5:0] run_reg;

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!reset_n_in);

	// Length of the running stall, so that no cycle can hold the core too long.
	always @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in)
			run_reg <= 6'h00;
		else
			run_reg <= stall_out ? run_reg + 6'h01 : 6'h00;
	end

	// One control write taken while the controller is idle.
	sequence s_ctl(bs, v);
		reg_write_in && reg_addr_in == 2'h2 && bit_set_instruction_in == bs
			&& reg_wdata_in == v && !stall_out;
	endsequence

	// Bus answers and stall lengths.
	a_rdata_idle: assert property (!reg_read_in |=> reg_rdata_out == 8'h00)
		else $error("read data not zero outside a read");
	a_unmapped_zero: assert property (reg_read_in && reg_addr_in == 2'h3 |=>
		reg_rdata_out == 8'h00) else $error("unmapped offset read not zero");
	a_read_stall: assert property (s_ctl(1'b1, 8'h01) |=>
		stall_out [*2] ##1 !stall_out) else $error("read stall length wrong");
	a_write_stall: assert property (s_ctl(1'b1, 8'h04) ##1 s_ctl(1'b1, 8'h06) |=>
		stall_out ##41 stall_out ##1 !stall_out) else $error("write stall length wrong");
	a_erase_stall: assert property (s_ctl(1'b0, 8'h10) ##1 s_ctl(1'b1, 8'h14)
		##1 s_ctl(1'b1, 8'h16) |=> stall_out ##48 stall_out ##1 !stall_out)
		else $error("erase stall length wrong");
	a_late_launch: assert property (s_ctl(1'b1, 8'h04) ##1 !reg_write_in
		##1 s_ctl(1'b1, 8'h06) |=> !stall_out) else $error("late launch accepted");
	a_stale_erase: assert property (s_ctl(1'b0, 8'h10) ##1 !reg_write_in
		##1 s_ctl(1'b1, 8'h14) ##1 s_ctl(1'b1, 8'h16) |=> !stall_out)
		else $error("stale erase select accepted");
	a_plain_launch: assert property (reg_write_in && reg_addr_in == 2'h2
		&& !bit_set_instruction_in && !stall_out |=> !stall_out)
		else $error("plain control write started a cycle");
	a_stall_bound: assert property (run_reg <= 6'h31)
		else $error("stall longer than an erase");
endmodule // nvm_ctrl_properties

// File: nvm_defines.vh
`ifndef NVM_DEFINES_VH
`define NVM_DEFINES_VH

// ==========================================================================
// Register map of the core-side port.
// ==========================================================================
`define NVM_OFS_ADDRESS 2'h0
`define NVM_OFS_DATA    2'h1
`define NVM_OFS_CONTROL 2'h2

// ==========================================================================
// Control register bit positions.
// ==========================================================================
`define NVM_BIT_READ    0
`define NVM_BIT_LAUNCH  1
`define NVM_BIT_WRITE_ENABLE_BIT    2
`define NVM_BIT_ERASE   4
`define NVM_BIT_BUSY    7

// ==========================================================================
// Array geometry, reset and erased values.
// ==========================================================================
`define NVM_ADDR_W      6
`define NVM_DEPTH       64
`define NVM_ROW_MSB     5
`define NVM_ROW_LSB     3
`define NVM_ERASED      8'hff
`define NVM_RESET_BYTE  8'h00

// ==========================================================================
// Timing: clock period and cell programming time, both in nanoseconds.
// ==========================================================================
`define NVM_CLK_PERIOD_NS 50
`define NVM_PROG_TIME_NS  2000
`define NVM_PROG_CYCLES   (`NVM_PROG_TIME_NS / `NVM_CLK_PERIOD_NS)

`endif

// File: tb_flash_data_memory_control.sv
`timescale 1ns/100ps

module tb_flash_data_memory_control;
	logic       clk_in;
	logic       reset_n_in;
	logic [1:0] a;
	logic [7:0] wd, rdata, val;
	logic [7:0] cur_run = 8'h00;
	logic [7:0] last_run = 8'h00;
	logic       w, r, bs, stall;
	logic       rd_seen = 1'b0;
	logic [7:0] exp_q[$];
	int         num_errors = 0;
	int         checks_done = 0;

	initial begin
		clk_in = 1'b0;
		forever #25 clk_in = ~clk_in;
	end

	nvm_core_model u_core (.clk_in(clk_in), .addr_out(a), .wdata_out(wd), .wr_out(w),
		.rd_out(r), .bs_out(bs));
	flash_data_memory_control u_dut (.clk_in(clk_in), .reset_n_in(reset_n_in),
		.reg_addr_in(a), .reg_wdata_in(wd), .reg_write_in(w), .reg_read_in(r),
		.bit_set_instruction_in(bs), .reg_rdata_out(rdata), .stall_out(stall));

	// Compares one value and counts it.
	task check(input logic [7:0] seen, input logic [7:0] exp, input string what);
		checks_done++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Takes the oldest note when read data stand, and measures stall runs.
	always @(posedge clk_in) begin
		if (rd_seen)
			check(rdata, exp_q.pop_front(), "read data");
		rd_seen <= r;
		if (stall)
			cur_run <= cur_run + 8'h01;
		else if (cur_run != 8'h00) begin
			last_run <= cur_run;
			cur_run <= 8'h00;
		end
	end

	// Read with a noted expectation.
	task rdx(input logic [1:0] ad, input logic [7:0] e);
		exp_q.push_back(e);
		u_core.rd(ad);
		u_core.idle(1);
	endtask

	// Row erase and byte write through the unlock sequence.
	task erase_row(input logic [7:0] ad);
		u_core.wr(2'h0, ad, 1'b0);
		u_core.wr(2'h2, 8'h10, 1'b0);
		u_core.wr(2'h2, 8'h14, 1'b1);
		u_core.wr(2'h2, 8'h16, 1'b1);
		u_core.idle(55);
		check(last_run, 8'h31, "erase stall");
	endtask
	task prog(input logic [7:0] ad, input logic [7:0] d);
		u_core.wr(2'h0, ad, 1'b0);
		u_core.wr(2'h1, d, 1'b0);
		u_core.wr(2'h2, 8'h04, 1'b1);
		u_core.wr(2'h2, 8'h06, 1'b1);
		u_core.idle(48);
		check(last_run, 8'h2a, "write stall");
	endtask
	task fetch(input logic [7:0] ad, input logic [7:0] e);
		u_core.wr(2'h0, ad, 1'b0);
		u_core.wr(2'h2, 8'h01, 1'b1);
		u_core.idle(4);
		check(last_run, 8'h02, "read stall");
		rdx(2'h1, e);
	endtask

	// Prints the counts and the verdict, then ends the run.
	task report_and_stop;
		$display("Checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// Main sequence.
	initial begin
		reset_n_in = 1'b0;
		void'($urandom(60608));
		val = 8'($urandom);
		repeat (6) @(posedge clk_in);
		reset_n_in <= 1'b1;
		for (int i = 0; i < 4; i++)
			rdx(2'(i), 8'h00);
		erase_row(8'h1f);
		erase_row(8'h10);
		prog(8'h13, val);
		fetch(8'h13, val);
		fetch(8'h17, 8'hff);
		fetch(8'h18, 8'hff);
		fetch(8'h13, val);
		u_core.wr(2'h0, 8'h17, 1'b0);
		rdx(2'h1, val);
		rdx(2'h0, 8'h17);
		rdx(2'h2, 8'h00);
		u_core.wr(2'h2, 8'h04, 1'b0);
		u_core.wr(2'h2, 8'h06, 1'b1);
		u_core.wr(2'h2, 8'h04, 1'b1);
		u_core.idle(1);
		u_core.wr(2'h2, 8'h06, 1'b1);
		u_core.wr(2'h2, 8'h10, 1'b0);
		u_core.idle(1);
		u_core.wr(2'h2, 8'h14, 1'b1);
		u_core.wr(2'h2, 8'h16, 1'b1);
		u_core.idle(55);
		fetch(8'h17, 8'hff);
		fetch(8'h13, val);
		report_and_stop();
	end

	// Watchdog against a hung sequence.
	initial begin
		repeat (3000) @(posedge clk_in);
		num_errors++;
		report_and_stop();
	end
endmodule // tb_flash_data_memory_control

bind flash_data_memory_control nvm_ctrl_properties u_props (.clk_in(clk_in),
	.reset_n_in(reset_n_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
	.reg_write_in(reg_write_in), .reg_read_in(reg_read_in),
	.bit_set_instruction_in(bit_set_instruction_in), .reg_rdata_out(reg_rdata_out),
	.stall_out(stall_out));
